// file: rtl/supervisor_pkg.sv
package supervisor_pkg;

    // timing, printed figures first, cycle counts derived from the clock period
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS = 1000000;
    localparam int DEB_FALL_NS = 32000;
    localparam int DEB_RISE_NS = 96000;
    localparam int DEB_RISE_LONG_NS = 256000;
    localparam int AUTO_WAIT_MS = 15000;
    // least times round up to whole cycles
    localparam int DEB_FALL_CYC = (DEB_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_RISE_CYC = (DEB_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_RISE_LONG_CYC = (DEB_RISE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUTO_WAIT_CYC = AUTO_WAIT_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int DEB_CNT_W = 14;
    localparam int WAIT_CNT_W = 30;

    // otp byte offsets
    localparam int OTP_BYTES = 10;
    localparam logic [3:0] OTP_CALIB_TEMP_IREF = 4'h0;
    localparam logic [3:0] OTP_CALIB_BUS_BANDGAP = 4'h1;
    localparam logic [3:0] OTP_THRESHOLD_NODE_ADDRESS = 4'h2;
    localparam logic [3:0] OTP_RUN_HOLD_CURRENT = 4'h3;
    localparam logic [3:0] OTP_SPEED_LIMITS = 4'h4;
    localparam logic [3:0] OTP_SAFE_POS_HIGH_DIRECTION_ACCEL = 4'h5;
    localparam logic [3:0] OTP_SAFE_POS_LOW_FAILSAFE_SLEEP = 4'h6;
    localparam logic [3:0] OTP_SUPPLY_STEP_LOCK = 4'h7;
    localparam logic [3:0] OTP_ALT_SAFE_POS_HIGH_OSC_TRIM = 4'h8;
    localparam logic [3:0] OTP_ALT_SAFE_POS_LOW_FAILSAFE_SLEEP = 4'h9;

    // otp field positions
    localparam int GLOBAL_LOCK_BIT = 0;
    localparam int FACTORY_LOCK_BIT = 1;
    localparam int LEVEL_SEL_LSB = 4;
    localparam int LONG_RISE_DEB_BIT = 7;
    localparam int ALT_BANK_BIT = 7;
    localparam int SAFE_HI_LSB = 5;
    localparam int SAFE_LO_LSB = 2;
    localparam int FAILSAFE_BIT = 1;
    localparam int SLEEP_EN_BIT = 0;

    // bits covered by the factory lock
    localparam logic [7:0] FACTORY_MASK_CALIB0 = 8'h7f;
    localparam logic [7:0] FACTORY_MASK_CALIB1 = 8'h3f;
    localparam logic [7:0] FACTORY_MASK_ALT_HI = 8'h1f;

    // delivered calibration contents, values arbitrary
    localparam logic [7:0] FACTORY_CALIB0 = 8'h35;
    localparam logic [7:0] FACTORY_CALIB1 = 8'h1a;

    typedef logic [OTP_BYTES-1:0][7:0] otp_image_type;

    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_STATUS_QUERY,
        CMD_FULL_STATUS_QUERY,
        CMD_SET_TARGET,
        CMD_SET_TARGET_SHORT,
        CMD_MOTION_PARAM_TARGET,
        CMD_GO_SAFE_POSITION,
        CMD_DUAL_TARGET,
        CMD_OTP_PROGRAM,
        CMD_OTP_READBACK,
        CMD_RAM_PARAM_WRITE
    } cmd_code_type;

    typedef struct packed {
        logic valid;
        cmd_code_type code;
        logic [3:0] addr;
        logic [15:0] data;
    } cmd_req_type;

    typedef struct packed {
        logic below_low_warning;
        logic above_restore;
        logic below_cutoff;
    } supply_in_type;

    typedef struct packed {
        logic busy;
        logic stab_phase;
        logic [15:0] act_pos;
    } motion_in_type;

    typedef struct packed {
        logic start;
        logic soft_stop;
        logic hard_stop;
        logic bridge_hiz;
        logic hold_current;
        logic [15:0] target;
    } motion_out_type;

    typedef struct packed {
        logic cutoff;
        logic low_warning;
        logic step_loss;
    } flags_type;

    typedef struct packed {
        logic [2:0] level_sel;
        logic long_rise;
        logic alt_bank;
        logic [10:0] safe_pos;
        logic failsafe;
        logic sleep_en;
    } work_cfg_type;

endpackage

// file: rtl/otp_fuse_array.sv
module otp_fuse_array (
    input wire logic i_clk,
    input wire logic i_factory_init,
    input wire logic i_zap,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_data,
    output supervisor_pkg::otp_image_type o_fuse,
    output logic o_locked
);

    typedef struct packed {
        supervisor_pkg::otp_image_type fuse;
    } fuse_state_type;

    fuse_state_type s_q;
    fuse_state_type s_d;
    logic [7:0] prot;

    // bits the factory lock shields for a given byte
    function automatic logic [7:0] factory_mask(input logic [3:0] addr);
        logic [7:0] m;
        m = 8'h00;
        if (addr == supervisor_pkg::OTP_CALIB_TEMP_IREF) begin
            m = supervisor_pkg::FACTORY_MASK_CALIB0;
        end else if (addr == supervisor_pkg::OTP_CALIB_BUS_BANDGAP) begin
            m = supervisor_pkg::FACTORY_MASK_CALIB1;
        end else if (addr == supervisor_pkg::OTP_ALT_SAFE_POS_HIGH_OSC_TRIM) begin
            m = supervisor_pkg::FACTORY_MASK_ALT_HI;
        end
        return m;
    endfunction

    assign o_fuse = s_q.fuse;
    // global lock covers every byte of the array
    assign o_locked = s_q.fuse[supervisor_pkg::OTP_SUPPLY_STEP_LOCK][supervisor_pkg::GLOBAL_LOCK_BIT];

    // zap only adds ones; a bit already at one stays as is
    always_comb begin
        s_d = s_q;
        prot = 8'h00;
        if (s_q.fuse[supervisor_pkg::OTP_SUPPLY_STEP_LOCK][supervisor_pkg::FACTORY_LOCK_BIT]) begin
            prot = factory_mask(i_addr);
        end
        if (i_zap && !o_locked && (i_addr < 4'(supervisor_pkg::OTP_BYTES))) begin
            s_d.fuse[i_addr] = s_q.fuse[i_addr] | (i_data & ~prot);
        end
    end

    // non-volatile: only the factory init clears it, never the core reset
    always_ff @(posedge i_clk or posedge i_factory_init) begin
        if (i_factory_init) begin
            s_q <= '0;
            s_q.fuse[supervisor_pkg::OTP_CALIB_TEMP_IREF] <= supervisor_pkg::FACTORY_CALIB0;
            s_q.fuse[supervisor_pkg::OTP_CALIB_BUS_BANDGAP] <= supervisor_pkg::FACTORY_CALIB1;
            s_q.fuse[supervisor_pkg::OTP_SUPPLY_STEP_LOCK][supervisor_pkg::FACTORY_LOCK_BIT] <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// file: rtl/supply_undervoltage_supervisor.sv
// Behaviour
// - cutoff and low-warning flags clear on status query while supply above restore.
// - low-warning level picks one of 8; restore follows it; cutoff fixed.
// - debounced fall below low-warning sets flag and starts decelerating stop.
// - stop finished above cutoff: hold current, keep target, no step-loss.
// - held state resumes to saved target once above restore, then stops.
// - cutoff during motion: hard stop, bridges off, cutoff and step-loss flags.
// - cutoff in stabilization phase sets cutoff flag only.
// - cutoff while stopped or held goes straight to wait, no step-loss.
// - fall below low-warning acted on after 32 us.
// - rise above restore acted on after 96 us, or 256 us when long.
// - wait state resumes to saved target if restored within 15 s.
// - wait state takes new targets from the four positioning commands.
// - after 15 s waiting lock out, target takes actual; exit by query.
// - dual-target refused until cutoff and step-loss flags are clear.
// - core reset clears working registers; wait logic runs while core powered.
// - otp bits read 0 until zapped; zapping a one is ignored.
// - one byte per program command; global lock refuses all zapping.
// - factory lock shields calibration bits; global lock shields bytes 0 to 9.
// - calibration bytes and factory lock hold contents at delivery.
// - zapped bits act only after power cycle; master re-addresses after it; the lock bits and the readback bank swap act at once.
// - alternate bank bit picks safe position, failsafe, sleep bytes.
// - safe position loads with two low bits zero.
// - after power-up registers reset and working copy loads from otp.
module supply_undervoltage_supervisor #(
    parameter int unsigned DEB_RISE_LONG_CYC = supervisor_pkg::DEB_RISE_LONG_CYC,
    parameter int unsigned AUTO_WAIT_CYC = supervisor_pkg::AUTO_WAIT_CYC
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_FACTORY_INIT,
    input wire supervisor_pkg::supply_in_type I_SUPPLY,
    input wire supervisor_pkg::motion_in_type I_MOTION,
    input wire supervisor_pkg::cmd_req_type I_CMD,
    input wire logic I_STEP_LOSS_CLR,
    output logic O_CMD_ACCEPT,
    output logic O_CMD_REFUSE,
    output supervisor_pkg::motion_out_type O_MOTION,
    output supervisor_pkg::flags_type O_FLAGS,
    output supervisor_pkg::work_cfg_type O_CFG,
    output logic [7:0] O_OTP_RDATA,
    output logic O_OTP_RVALID
);

    typedef enum logic [2:0] {
        ST_STOPPED,
        ST_STARTING,
        ST_MOVING,
        ST_SOFT_STOPPING,
        ST_HELD_LOW,
        ST_HARD_STOP_LOW,
        ST_AUTO_WAIT,
        ST_LOCKOUT
    } sup_state_type;

    typedef struct packed {
        sup_state_type st;
        logic loaded;
        logic low;
        logic [supervisor_pkg::DEB_CNT_W-1:0] deb_cnt;
        logic [supervisor_pkg::WAIT_CNT_W-1:0] wait_cnt;
        supervisor_pkg::flags_type flags;
        supervisor_pkg::work_cfg_type cfg;
        supervisor_pkg::motion_out_type mo;
        logic [7:0] rdata;
        logic rvalid;
    } sup_reg_type;

    sup_reg_type r_q;
    sup_reg_type r_d;
    supervisor_pkg::otp_image_type fuse;
    logic otp_locked;
    logic zap;
    logic fall_ev;
    logic restore_ok;
    logic query;
    logic tgt_ok;
    logic set_sl;
    logic [15:0] new_tgt;
    logic [supervisor_pkg::DEB_CNT_W-1:0] rise_last;

    // the four commands that carry a new target
    function automatic logic is_target_cmd(input supervisor_pkg::cmd_code_type c);
        return (c == supervisor_pkg::CMD_SET_TARGET) ||
               (c == supervisor_pkg::CMD_SET_TARGET_SHORT) ||
               (c == supervisor_pkg::CMD_MOTION_PARAM_TARGET) ||
               (c == supervisor_pkg::CMD_GO_SAFE_POSITION);
    endfunction

    // working copy of the otp image, alternate bank chosen by its own bit
    function automatic supervisor_pkg::work_cfg_type cfg_from(
        input supervisor_pkg::otp_image_type img
    );
        supervisor_pkg::work_cfg_type c;
        logic [7:0] hi;
        logic [7:0] lo;
        c.level_sel = img[supervisor_pkg::OTP_SUPPLY_STEP_LOCK][supervisor_pkg::LEVEL_SEL_LSB +: 3];
        c.long_rise = img[supervisor_pkg::OTP_SUPPLY_STEP_LOCK][supervisor_pkg::LONG_RISE_DEB_BIT];
        c.alt_bank = img[supervisor_pkg::OTP_CALIB_TEMP_IREF][supervisor_pkg::ALT_BANK_BIT];
        hi = img[supervisor_pkg::OTP_SAFE_POS_HIGH_DIRECTION_ACCEL];
        lo = img[supervisor_pkg::OTP_SAFE_POS_LOW_FAILSAFE_SLEEP];
        if (c.alt_bank) begin
            hi = img[supervisor_pkg::OTP_ALT_SAFE_POS_HIGH_OSC_TRIM];
            lo = img[supervisor_pkg::OTP_ALT_SAFE_POS_LOW_FAILSAFE_SLEEP];
        end
        // stored position lacks the two lsbs, they load as zero
        c.safe_pos = {hi[supervisor_pkg::SAFE_HI_LSB +: 3], lo[supervisor_pkg::SAFE_LO_LSB +: 6],
                      2'h0};
        c.failsafe = lo[supervisor_pkg::FAILSAFE_BIT];
        c.sleep_en = lo[supervisor_pkg::SLEEP_EN_BIT];
        return c;
    endfunction

    otp_fuse_array u_fuse (
        .i_clk(I_CLK),
        .i_factory_init(I_FACTORY_INIT),
        .i_zap(zap),
        .i_addr(I_CMD.addr),
        .i_data(I_CMD.data[7:0]),
        .o_fuse(fuse),
        .o_locked(otp_locked)
    );

    // outputs straight from the state register
    assign O_MOTION = r_q.mo;
    assign O_FLAGS = r_q.flags;
    assign O_CFG = r_q.cfg;
    assign O_OTP_RDATA = r_q.rdata;
    assign O_OTP_RVALID = r_q.rvalid;
    assign restore_ok = !r_q.low;

    // command acceptance; answers in the cycle the command is presented
    always_comb begin
        query = I_CMD.valid && ((I_CMD.code == supervisor_pkg::CMD_STATUS_QUERY) ||
                                (I_CMD.code == supervisor_pkg::CMD_FULL_STATUS_QUERY));
        tgt_ok = 1'b0;
        zap = 1'b0;
        O_CMD_ACCEPT = 1'b0;
        if (I_CMD.valid) begin
            if (is_target_cmd(I_CMD.code)) begin
                tgt_ok = r_q.loaded && (r_q.st != ST_LOCKOUT);
            end else if (I_CMD.code == supervisor_pkg::CMD_DUAL_TARGET) begin
                // dual target waits for the cutoff and step-loss flags to be cleared
                tgt_ok = r_q.loaded && (r_q.st != ST_LOCKOUT) &&
                         !r_q.flags.cutoff && !r_q.flags.step_loss;
            end else if (I_CMD.code == supervisor_pkg::CMD_OTP_PROGRAM) begin
                zap = !otp_locked && (I_CMD.addr < 4'(supervisor_pkg::OTP_BYTES));
                O_CMD_ACCEPT = zap;
            end else if (I_CMD.code == supervisor_pkg::CMD_OTP_READBACK) begin
                O_CMD_ACCEPT = I_CMD.addr < 4'(supervisor_pkg::OTP_BYTES);
            end else if (I_CMD.code != supervisor_pkg::CMD_NONE) begin
                O_CMD_ACCEPT = 1'b1;
            end
        end
        if (tgt_ok) begin
            O_CMD_ACCEPT = 1'b1;
        end
        O_CMD_REFUSE = I_CMD.valid && !O_CMD_ACCEPT;
    end

    // next state
    always_comb begin
        r_d = r_q;
        fall_ev = 1'b0;
        set_sl = 1'b0;
        new_tgt = I_CMD.data;
        r_d.mo.start = 1'b0;
        r_d.mo.soft_stop = 1'b0;
        r_d.mo.hard_stop = 1'b0;
        r_d.rvalid = 1'b0;
        rise_last = supervisor_pkg::DEB_CNT_W'(supervisor_pkg::DEB_RISE_CYC - 1);
        if (r_q.cfg.long_rise) begin
            rise_last = supervisor_pkg::DEB_CNT_W'(DEB_RISE_LONG_CYC - 1);
        end

        // working copy taken once per core power-up, so later zaps wait
        if (!r_q.loaded) begin
            r_d.cfg = cfg_from(fuse);
            r_d.loaded = 1'b1;
            r_d.mo.bridge_hiz = 1'b0;
        end

        // run-time overwrite of the supply settings in the working copy
        if (I_CMD.valid && (I_CMD.code == supervisor_pkg::CMD_RAM_PARAM_WRITE)) begin
            r_d.cfg.level_sel = I_CMD.data[supervisor_pkg::LEVEL_SEL_LSB +: 3];
            r_d.cfg.long_rise = I_CMD.data[supervisor_pkg::LONG_RISE_DEB_BIT];
        end

        // readback swaps in the alternate bank when it is selected
        if (I_CMD.valid && O_CMD_ACCEPT && (I_CMD.code == supervisor_pkg::CMD_OTP_READBACK)) begin
            r_d.rvalid = 1'b1;
            r_d.rdata = fuse[I_CMD.addr];
            if (fuse[supervisor_pkg::OTP_CALIB_TEMP_IREF][supervisor_pkg::ALT_BANK_BIT]) begin
                if (I_CMD.addr == supervisor_pkg::OTP_SAFE_POS_HIGH_DIRECTION_ACCEL) begin
                    r_d.rdata = fuse[supervisor_pkg::OTP_ALT_SAFE_POS_HIGH_OSC_TRIM];
                end else if (I_CMD.addr == supervisor_pkg::OTP_SAFE_POS_LOW_FAILSAFE_SLEEP) begin
                    r_d.rdata = fuse[supervisor_pkg::OTP_ALT_SAFE_POS_LOW_FAILSAFE_SLEEP];
                end
            end
        end

        // unsymmetrical debounce: short on the way down, long on the way up
        if (!r_q.low) begin
            if (I_SUPPLY.below_low_warning) begin
                if (r_q.deb_cnt == supervisor_pkg::DEB_CNT_W'(supervisor_pkg::DEB_FALL_CYC - 1)) begin
                    r_d.low = 1'b1;
                    r_d.deb_cnt = '0;
                    fall_ev = 1'b1;
                end else begin
                    r_d.deb_cnt = r_q.deb_cnt + 1'b1;
                end
            end else begin
                r_d.deb_cnt = '0;
            end
        end else begin
            if (I_SUPPLY.above_restore) begin
                if (r_q.deb_cnt == rise_last) begin
                    r_d.low = 1'b0;
                    r_d.deb_cnt = '0;
                end else begin
                    r_d.deb_cnt = r_q.deb_cnt + 1'b1;
                end
            end else begin
                r_d.deb_cnt = '0;
            end
        end
        // cutoff implies low; force it so a fast cutoff cannot look restored
        if (I_SUPPLY.below_cutoff) begin
            fall_ev = !r_q.low;
            r_d.low = 1'b1;
            r_d.deb_cnt = '0;
        end

        // accepted targets are stored in any state that allows them
        if (I_CMD.code == supervisor_pkg::CMD_GO_SAFE_POSITION) begin
            new_tgt = {{5{r_q.cfg.safe_pos[10]}}, r_q.cfg.safe_pos};
        end
        if (tgt_ok) begin
            r_d.mo.target = new_tgt;
        end

        case (r_q.st)
            ST_STOPPED: begin
                if (I_SUPPLY.below_cutoff) begin
                    r_d.st = ST_AUTO_WAIT;
                    r_d.wait_cnt = '0;
                    r_d.mo.bridge_hiz = 1'b1;
                end else if (tgt_ok) begin
                    r_d.mo.start = 1'b1;
                    r_d.st = ST_STARTING;
                end
            end
            ST_STARTING, ST_MOVING, ST_SOFT_STOPPING: begin
                if (I_SUPPLY.below_cutoff) begin
                    r_d.mo.hard_stop = 1'b1;
                    r_d.mo.bridge_hiz = 1'b1;
                    r_d.st = ST_HARD_STOP_LOW;
                    set_sl = !I_MOTION.stab_phase;
                end else if (r_q.st == ST_SOFT_STOPPING) begin
                    // stop finished above cutoff: keep target, hold position
                    if (!I_MOTION.busy) begin
                        r_d.st = ST_HELD_LOW;
                        r_d.mo.hold_current = 1'b1;
                    end
                end else if (fall_ev) begin
                    r_d.mo.soft_stop = 1'b1;
                    r_d.st = ST_SOFT_STOPPING;
                end else if (I_MOTION.busy) begin
                    r_d.st = ST_MOVING;
                end else if (r_q.st == ST_MOVING) begin
                    r_d.st = ST_STOPPED;
                end
            end
            ST_HELD_LOW: begin
                if (I_SUPPLY.below_cutoff) begin
                    r_d.mo.hold_current = 1'b0;
                    r_d.mo.bridge_hiz = 1'b1;
                    r_d.st = ST_AUTO_WAIT;
                    r_d.wait_cnt = '0;
                end else if (restore_ok) begin
                    r_d.mo.hold_current = 1'b0;
                    r_d.mo.start = 1'b1;
                    r_d.st = ST_STARTING;
                end
            end
            ST_HARD_STOP_LOW: begin
                r_d.st = ST_AUTO_WAIT;
                r_d.wait_cnt = '0;
            end
            ST_AUTO_WAIT: begin
                // resume wins over timeout when both fall on the same cycle
                if (restore_ok) begin
                    r_d.mo.bridge_hiz = 1'b0;
                    r_d.mo.start = 1'b1;
                    r_d.st = ST_STARTING;
                end else if (r_q.wait_cnt ==
                             supervisor_pkg::WAIT_CNT_W'(AUTO_WAIT_CYC - 1)) begin
                    r_d.st = ST_LOCKOUT;
                    r_d.mo.target = I_MOTION.act_pos;
                end else begin
                    r_d.wait_cnt = r_q.wait_cnt + 1'b1;
                end
            end
            ST_LOCKOUT: begin
                // bridges stay off until software acknowledges a good supply
                if (restore_ok && query) begin
                    r_d.mo.bridge_hiz = 1'b0;
                    r_d.st = ST_STOPPED;
                end
            end
            default: begin
                r_d.st = ST_STOPPED;
            end
        endcase

        // sticky flags: a set in the clear cycle wins
        r_d.flags.cutoff = I_SUPPLY.below_cutoff ||
                           (r_q.flags.cutoff && !(query && restore_ok));
        r_d.flags.low_warning = fall_ev ||
                                (r_q.flags.low_warning && !(query && restore_ok));
        r_d.flags.step_loss = set_sl || (r_q.flags.step_loss && !I_STEP_LOSS_CLR);
    end

    // core power-on reset clears every working register except bridge_hiz, which it sets
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            r_q <= '0;
            r_q.st <= ST_STOPPED;
            r_q.mo.bridge_hiz <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

endmodule

// file: tb/supervisor_checker.sv
module supervisor_checker (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire supervisor_pkg::supply_in_type I_SUPPLY,
    input wire supervisor_pkg::motion_in_type I_MOTION,
    input wire supervisor_pkg::cmd_req_type I_CMD,
    input wire logic O_CMD_REFUSE,
    input wire supervisor_pkg::motion_out_type O_MOTION,
    input wire supervisor_pkg::flags_type O_FLAGS,
    input wire supervisor_pkg::work_cfg_type O_CFG
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] low_q;
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    // run length of the raw low level, saturates so it never wraps back
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST)
            low_q <= '0;
        else
            low_q <= !I_SUPPLY.below_low_warning ? '0 : low_q + {13'h0, !(&low_q)};
    end
    fall_debounce_a: assert property ($rose(O_FLAGS.low_warning) |->
        low_q >= supervisor_pkg::DEB_FALL_CYC || $past(I_SUPPLY.below_cutoff))
        else $error("early low warning");
    fall_act_a: assert property (low_q == supervisor_pkg::DEB_FALL_CYC |->
        O_FLAGS.low_warning) else $error("late low warning");
    clear_by_query_a: assert property ($fell(O_FLAGS.cutoff) |-> $past(I_CMD.valid) &&
        $past(I_CMD.code) inside {supervisor_pkg::CMD_STATUS_QUERY,
        supervisor_pkg::CMD_FULL_STATUS_QUERY}) else $error("cutoff flag cleared alone");
    hard_stop_a: assert property (I_SUPPLY.below_cutoff && I_MOTION.busy |=>
        O_FLAGS.cutoff && O_MOTION.bridge_hiz) else $error("no hard stop on cutoff");
    stab_cut_a: assert property (I_SUPPLY.below_cutoff && I_MOTION.stab_phase &&
        !O_FLAGS.step_loss |=> !O_FLAGS.step_loss) else $error("step loss in stabilization");
    stopped_cut_a: assert property (I_SUPPLY.below_cutoff && !I_MOTION.busy &&
        !O_MOTION.start && !O_FLAGS.step_loss |=> !O_FLAGS.step_loss) else $error("step loss set");
    dual_refuse_a: assert property (I_CMD.valid && (O_FLAGS.cutoff || O_FLAGS.step_loss) &&
        I_CMD.code == supervisor_pkg::CMD_DUAL_TARGET |-> O_CMD_REFUSE) else $error("dual taken");
    hold_a: assert property (O_MOTION.hold_current |-> !O_MOTION.bridge_hiz)
        else $error("hold with bridges off");
    safe_bits_a: assert property (O_CFG.safe_pos[1:0] == 2'h0) else $error("low bits set");
endmodule
bind supply_undervoltage_supervisor supervisor_checker u_supervisor_checker (
    .I_CLK, .I_SYS_RST, .I_SUPPLY, .I_MOTION, .I_CMD, .O_CMD_REFUSE, .O_MOTION, .O_FLAGS, .O_CFG
);

// file: tb/bus_master_model.sv
module bus_master_model (
    input wire logic i_clk,
    input wire logic i_accept,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    output supervisor_pkg::cmd_req_type o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_cmd = '0;
    // one-cycle strobe; accept is read before the edge's updates land
    task automatic send(input supervisor_pkg::cmd_code_type c, input logic [3:0] ad,
        input logic [15:0] v, output logic acc);
        @(negedge i_clk);
        o_cmd = '{1'h1, c, ad, v};
        @(posedge i_clk);
        acc = i_accept;
        @(negedge i_clk);
        o_cmd.valid = 1'h0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        logic acc;
        send(supervisor_pkg::CMD_OTP_READBACK, ad, 16'h0000, acc);
        for (int k = 0; k < 3 && i_rvalid !== 1'h1; k++) @(negedge i_clk);
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask
    // every zap is read back so a bad byte shows at once
    task automatic prog(input logic [3:0] ad, input logic [7:0] v, output logic [7:0] d);
        logic acc;
        send(supervisor_pkg::CMD_OTP_PROGRAM, ad, {8'h00, v}, acc);
        rd(ad, d);
    endtask
endmodule

// file: tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, finit, step_clr, acc, refuse, rvalid, a;
    logic [7:0] rdata, d;
    int fails, comparisons;
    supervisor_pkg::supply_in_type sup;
    supervisor_pkg::motion_in_type mot;
    supervisor_pkg::cmd_req_type cmd;
    supervisor_pkg::motion_out_type mo;
    supervisor_pkg::flags_type fl;
    supervisor_pkg::work_cfg_type cfg;
    supply_undervoltage_supervisor #(.DEB_RISE_LONG_CYC(20), .AUTO_WAIT_CYC(200))
    u_supply_undervoltage_supervisor (.I_CLK(clk), .I_SYS_RST(rst), .I_FACTORY_INIT(finit),
        .I_SUPPLY(sup), .I_MOTION(mot), .I_CMD(cmd), .I_STEP_LOSS_CLR(step_clr),
        .O_CMD_ACCEPT(acc), .O_CMD_REFUSE(refuse), .O_MOTION(mo), .O_FLAGS(fl), .O_CFG(cfg),
        .O_OTP_RDATA(rdata), .O_OTP_RVALID(rvalid));
    bus_master_model u_bus_master_model (.i_clk(clk), .i_accept(acc), .i_rvalid(rvalid),
        .i_rdata(rdata), .o_cmd(cmd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tx(input supervisor_pkg::cmd_code_type c, input logic [15:0] v);
        u_bus_master_model.send(c, 4'h0, v, a);
    endtask
    task automatic wait_start;
        for (int k = 0; k < 40 && mo.start !== 1'h1; k++) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d mismatches=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // cut a hang well past the expected run of under two thousand cycles
    initial begin
        #250000;
        fails++;
        tally_and_finish();
    end
    // supply bits: low warning, restore, cutoff
    initial begin
        rst = 1'h1;
        finit = 1'h1;
        step_clr = 1'h0;
        sup = 3'h2;
        mot = '0;
        cyc(20);
        finit = 1'h0;
        rst = 1'h0;
        cyc(2);
        chk(cfg, 0);
        u_bus_master_model.rd(4'h0, d);
        chk(d, supervisor_pkg::FACTORY_CALIB0);
        u_bus_master_model.rd(4'h7, d);
        chk(d, 8'h02);
        u_bus_master_model.prog(4'h2, 8'h05, d);
        chk(d, 8'h05);
        u_bus_master_model.prog(4'h2, 8'h0a, d);
        chk(d, 8'h0f);
        u_bus_master_model.prog(4'h0, 8'hff, d);
        chk(d, supervisor_pkg::FACTORY_CALIB0 | 8'h80);
        u_bus_master_model.prog(4'h9, 8'h0d, d);
        chk(d, 8'h0d);
        u_bus_master_model.prog(4'h7, 8'h80, d);
        chk(cfg.long_rise, 0);
        u_bus_master_model.prog(4'h7, 8'h01, d);
        chk(d, 8'h83);
        u_bus_master_model.send(supervisor_pkg::CMD_OTP_PROGRAM, 4'h3, 16'h00ff, a);
        chk(a, 0);
        u_bus_master_model.send(supervisor_pkg::CMD_OTP_READBACK, 4'ha, 16'h0000, a);
        chk(a, 0);
        for (int i = 0; i < 8; i++) begin
            tx(supervisor_pkg::CMD_RAM_PARAM_WRITE, 16'h0080 | 16'(i << 4));
            chk(cfg.level_sel, i);
        end
        tx(supervisor_pkg::CMD_SET_TARGET, 16'h0123);
        mot.busy = 1'h1;
        sup = 3'h4;
        for (int k = 0; k < 1300 && mo.soft_stop !== 1'h1; k++) @(negedge clk);
        chk({mo.soft_stop, fl.low_warning}, 2'h3);
        mot.busy = 1'h0;
        cyc(2);
        chk({mo.hold_current, fl.step_loss, mo.target}, 32'h0002_0123);
        sup = 3'h2;
        wait_start();
        chk({mo.start, mo.target}, 32'h0001_0123);
        mot.busy = 1'h1;
        cyc(3);
        sup = 3'h1;
        cyc(1);
        chk({mo.hard_stop, mo.bridge_hiz, fl.cutoff, fl.step_loss}, 4'hf);
        mot = '{1'h0, 1'h0, 16'h0777};
        for (int c = 1; c < 7; c++) begin
            tx(supervisor_pkg::cmd_code_type'(c), 16'h0200);
            chk(a, 1);
        end
        tx(supervisor_pkg::CMD_DUAL_TARGET, 16'h0040);
        chk(a, 0);
        cyc(210);
        chk({mo.bridge_hiz, mo.target}, 32'h0001_0777);
        tx(supervisor_pkg::CMD_SET_TARGET, 16'h0300);
        chk(a, 0);
        sup = 3'h2;
        cyc(30);
        tx(supervisor_pkg::CMD_STATUS_QUERY, 16'h0000);
        chk({fl.cutoff, fl.low_warning}, 0);
        tx(supervisor_pkg::CMD_DUAL_TARGET, 16'h0040);
        chk(a, 0);
        step_clr = 1'h1;
        cyc(1);
        step_clr = 1'h0;
        tx(supervisor_pkg::CMD_DUAL_TARGET, 16'h0040);
        chk(a, 1);
        mot.busy = 1'h1;
        cyc(2);
        mot.busy = 1'h0;
        cyc(2);
        sup = 3'h1;
        cyc(2);
        chk({fl.step_loss, mo.bridge_hiz}, 2'h1);
        sup = 3'h2;
        wait_start();
        chk(mo.start, 1);
        mot = '{1'h1, 1'h1, 16'h0000};
        cyc(2);
        sup = 3'h1;
        cyc(2);
        chk({fl.cutoff, fl.step_loss}, 2'h2);
        sup = 3'h2;
        mot = '0;
        rst = 1'h1;
        cyc(2);
        rst = 1'h0;
        cyc(2);
        chk(fl, 0);
        chk(cfg, 32'h0000_6031);
        tally_and_finish();
    end
endmodule
